// file: rtl/drcu_pkg.sv
/*
  Shared constants, types and helper functions of the dual output route
  command unit. Assumes ASCII characters on the ring and one 10 MHz clock.
*/
package drcu_pkg;

  // ****************************************
  // Frame characters and commands
  // ****************************************
  localparam logic [7:0] CH_STX = 8'h02;
  localparam logic [7:0] CH_ETX = 8'h03;
  localparam logic [7:0] CH_ERR = 8'h45;
  localparam logic [7:0] CH_PROTO = 8'h50;
  localparam logic [7:0] CH_CHKSUM = 8'h43;
  localparam logic [7:0] OWN_CLASS = 8'h6D;
  localparam logic [7:0] CMD_O1_IN2 = 8'h61;
  localparam logic [7:0] CMD_O1_IN1 = 8'h74;
  localparam logic [7:0] CMD_O2_IN2 = 8'h62;
  localparam logic [7:0] CMD_O2_IN1 = 8'h73;
  localparam logic [7:0] CMD_FO_EN = 8'h6A;

  // ****************************************
  // Frame layout, counted from the class character
  // ****************************************
  localparam logic [5:0] IDX_TYPE = 6'h00;
  localparam logic [5:0] IDX_ADDRH = 6'h01;
  localparam logic [5:0] IDX_ADDRL = 6'h02;
  localparam logic [5:0] IDX_BODY = 6'h03;
  localparam logic [5:0] LEN_MIN = 6'h03;
  localparam logic [5:0] LEN_CMD = 6'h06;
  localparam logic [5:0] LEN_CMD_STAT = 6'h08;
  localparam logic [5:0] LEN_SUM_START = 6'h02;
  localparam logic [5:0] ACK_LAST = 6'h09;
  localparam int MEM_DEPTH = 32;
  localparam int MEM_AW = 5;
  localparam logic [5:0] MEM_FULL = 6'h20;

  // ****************************************
  // Status byte layout and reset values
  // ****************************************
  localparam int ST_SYNC1 = 0;
  localparam int ST_SYNC2 = 1;
  localparam int ST_TGT1 = 2;
  localparam int ST_TGT2 = 3;
  localparam int ST_RSVD = 4;
  localparam int ST_ACT1 = 5;
  localparam int ST_ACT2 = 6;
  localparam int ST_FO = 7;
  localparam logic RST_TGT1 = 1'b0;
  localparam logic RST_TGT2 = 1'b1;
  localparam logic RST_FO = 1'b1;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {S_IDLE, S_RX, S_EXEC, S_TX} drcu_state_e;
  typedef enum logic [1:0] {K_FWD, K_ACK, K_EP, K_EC} drcu_kind_e;

  typedef struct packed {
    logic ff1;
    logic ff2;
    logic ff3;
    logic level;
  } drcu_sync_s;

  typedef struct packed {
    logic tgt1;
    logic tgt2;
    logic act1;
    logic act2;
    logic fo;
  } drcu_route_s;

  typedef struct packed {
    logic [7:0] valid_data;
    logic valid;
  } drcu_tx_s;

  typedef struct packed {
    drcu_state_e state;
    drcu_kind_e kind;
    drcu_route_s route;
    logic [5:0] cnt;
    logic ovf;
    logic [7:0] sum;
    logic [7:0] c1;
    logic [7:0] c2;
    logic [7:0] ftype;
    logic [7:0] fah;
    logic [7:0] fal;
    logic [7:0] fbody;
    logic [5:0] seq;
    logic fetch;
    drcu_tx_s tx;
    logic rx_ready;
    logic [7:0] status;
    logic [5:0] leds;
  } drcu_core_s;

  localparam drcu_route_s ROUTE_RST = '{tgt1: RST_TGT1, tgt2: RST_TGT2, act1: RST_TGT1,
                                        act2: RST_TGT2, fo: RST_FO};

  // ****************************************
  // Hex character helpers
  // ****************************************
  function automatic logic [7:0] nib2hex(input logic [3:0] n);
    nib2hex = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h57 + {4'h0, n});
  endfunction

  // Bit 4 flags a legal hex digit
  function automatic logic [4:0] hex2nib(input logic [7:0] c);
    logic [7:0] t;
    t = 8'h00;
    hex2nib = 5'h00;
    if (c >= 8'h30 && c <= 8'h39) begin
      t = c - 8'h30;
      hex2nib = {1'b1, t[3:0]};
    end else if (c >= 8'h61 && c <= 8'h66) begin
      t = c - 8'h57;
      hex2nib = {1'b1, t[3:0]};
    end else if (c >= 8'h41 && c <= 8'h46) begin
      t = c - 8'h37;
      hex2nib = {1'b1, t[3:0]};
    end
  endfunction

endpackage

// file: rtl/drcu_sync.sv
/*
  Three stage synchroniser for one sync presence pin.
  Assumes the pin is asynchronous to clk_i; level follows once stages two and
  three agree.
*/
`timescale 1ns/1ns
`default_nettype none
module drcu_sync (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic pin_i,
  output logic level_o
);

  drcu_pkg::drcu_sync_s st_q;
  drcu_pkg::drcu_sync_s st_d;

  always_comb begin
    st_d = st_q;
    st_d.ff1 = pin_i;
    st_d.ff2 = st_q.ff1;
    st_d.ff3 = st_q.ff2;
    // Stage one is never looked at, only stages two and three
    if (st_q.ff2 == st_q.ff3) begin
      st_d.level = st_q.ff3;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level_o = st_q.level;

endmodule
`default_nettype wire

// file: rtl/drcu_char_mem.sv
/*
  Small frame character store, one write port, registered read data.
  Assumes read data is used one cycle after the address is presented.
*/
`timescale 1ns/1ns
`default_nettype none
module drcu_char_mem (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic wr_en_i,
  input wire logic [drcu_pkg::MEM_AW-1:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [drcu_pkg::MEM_AW-1:0] rd_addr_i,
  output logic [7:0] rd_data_o
);

  logic [7:0] mem_q [drcu_pkg::MEM_DEPTH];
  logic [7:0] rd_q;

  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_q <= 8'h00;
    end else begin
      rd_q <= mem_q[rd_addr_i];
    end
  end

  assign rd_data_o = rd_q;

endmodule
`default_nettype wire

// file: rtl/drcu_ring_slave.sv
/*
  Ring slave command unit for a two input, two output video route switch.
  Assumes ring characters arrive and leave as bytes on clk_i from a serial
  front end, and sync presence pins are asynchronous.
*/
`timescale 1ns/1ns
`default_nettype none

module drcu_ring_slave (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [15:0] own_addr_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  output logic rx_ready_o,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  input wire logic input_one_sync_i,
  input wire logic input_two_sync_i,
  output logic out1_src_o,
  output logic out2_src_o,
  output logic [7:0] routing_and_sync_status_o,
  output logic in1_led_o,
  output logic in2_led_o,
  output logic out1_led_green_o,
  output logic out1_led_orange_o,
  output logic out2_led_green_o,
  output logic out2_led_orange_o
);

  // ****************************************
  // Sync presence pins and frame store
  // ****************************************
  logic input_one_sync_present;
  logic input_two_sync_present;
  logic mem_wr;
  logic [drcu_pkg::MEM_AW-1:0] mem_rd_addr;
  logic [7:0] mem_rd_data;
  drcu_pkg::drcu_core_s st_q;
  drcu_pkg::drcu_core_s st_d;

  drcu_sync u_sync1 (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .pin_i(input_one_sync_i),
    .level_o(input_one_sync_present)
  );

  drcu_sync u_sync2 (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .pin_i(input_two_sync_i),
    .level_o(input_two_sync_present)
  );

  // Frames of up to 32 characters are held so a foreign or faulty frame can be replayed intact
  drcu_char_mem u_mem (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .wr_en_i(mem_wr),
    .wr_addr_i(st_q.cnt[drcu_pkg::MEM_AW-1:0]),
    .wr_data_i(rx_data_i),
    .rd_addr_i(mem_rd_addr),
    .rd_data_o(mem_rd_data)
  );

  // ****************************************
  // Next state
  // ****************************************
  logic rx_take;
  logic [4:0] chk_hi;
  logic [4:0] chk_lo;
  logic chk_ok;
  logic body_ok;
  logic addr_match;
  logic [7:0] stat_hi;
  logic [7:0] stat_lo;
  logic [7:0] ack_sum;
  logic [7:0] tx_char;
  logic tx_last;
  logic [5:0] seq_m1;
  logic tx_load;

  always_comb begin
    st_d = st_q;
    rx_take = rx_valid_i && st_q.rx_ready;
    mem_wr = 1'b0;
    seq_m1 = st_q.seq - 6'h01;
    mem_rd_addr = seq_m1[drcu_pkg::MEM_AW-1:0];

    // Actual source follows target unless failover finds the target dark
    st_d.route.act1 = st_q.route.tgt1;
    if (st_q.route.fo && !(st_q.route.tgt1 ? input_two_sync_present : input_one_sync_present)) begin
      st_d.route.act1 = !st_q.route.tgt1;
    end
    st_d.route.act2 = st_q.route.tgt2;
    if (st_q.route.fo && !(st_q.route.tgt2 ? input_two_sync_present : input_one_sync_present)) begin
      st_d.route.act2 = !st_q.route.tgt2;
    end

    st_d.status = 8'h00;
    st_d.status[drcu_pkg::ST_SYNC1] = input_one_sync_present;
    st_d.status[drcu_pkg::ST_SYNC2] = input_two_sync_present;
    st_d.status[drcu_pkg::ST_TGT1] = st_q.route.tgt1;
    st_d.status[drcu_pkg::ST_TGT2] = st_q.route.tgt2;
    st_d.status[drcu_pkg::ST_ACT1] = st_q.route.act1;
    st_d.status[drcu_pkg::ST_ACT2] = st_q.route.act2;
    st_d.status[drcu_pkg::ST_FO] = st_q.route.fo;
    st_d.leds = {input_one_sync_present, input_two_sync_present,
                 !st_q.route.act1, st_q.route.act1, !st_q.route.act2, st_q.route.act2};

    chk_hi = drcu_pkg::hex2nib(st_q.c2);
    chk_lo = drcu_pkg::hex2nib(st_q.c1);
    chk_ok = chk_hi[4] && chk_lo[4] && ({chk_hi[3:0], chk_lo[3:0]} == st_q.sum);
    body_ok = !st_q.ovf && (st_q.cnt == drcu_pkg::LEN_CMD || st_q.cnt == drcu_pkg::LEN_CMD_STAT) &&
              (st_q.fbody == drcu_pkg::CMD_O1_IN2 || st_q.fbody == drcu_pkg::CMD_O1_IN1 ||
               st_q.fbody == drcu_pkg::CMD_O2_IN2 || st_q.fbody == drcu_pkg::CMD_O2_IN1 ||
               st_q.fbody == drcu_pkg::CMD_FO_EN);
    addr_match = st_q.cnt >= drcu_pkg::LEN_MIN && st_q.ftype == drcu_pkg::OWN_CLASS &&
                 {st_q.fah, st_q.fal} == own_addr_i;

    // Reply character sequence for acknowledge, forward and error replies
    stat_hi = drcu_pkg::nib2hex(st_q.status[7:4]);
    stat_lo = drcu_pkg::nib2hex(st_q.status[3:0]);
    ack_sum = st_q.ftype + st_q.fah + st_q.fal + st_q.fbody + stat_hi + stat_lo;
    tx_char = drcu_pkg::CH_ETX;
    tx_last = 1'b0;
    if (st_q.seq == 6'h00) begin
      tx_char = drcu_pkg::CH_STX;
    end else if (st_q.kind == drcu_pkg::K_ACK) begin
      unique case (st_q.seq)
        6'h01: tx_char = st_q.ftype;
        6'h02: tx_char = st_q.fah;
        6'h03: tx_char = st_q.fal;
        6'h04: tx_char = st_q.fbody;
        6'h05: tx_char = stat_hi;
        6'h06: tx_char = stat_lo;
        6'h07: tx_char = drcu_pkg::nib2hex(ack_sum[7:4]);
        6'h08: tx_char = drcu_pkg::nib2hex(ack_sum[3:0]);
        default: tx_char = drcu_pkg::CH_ETX;
      endcase
      tx_last = st_q.seq == drcu_pkg::ACK_LAST;
    end else if (st_q.seq <= st_q.cnt) begin
      tx_char = mem_rd_data;
    end else if (st_q.kind != drcu_pkg::K_FWD && st_q.seq == st_q.cnt + 6'h01) begin
      tx_char = drcu_pkg::CH_ERR;
    end else if (st_q.kind != drcu_pkg::K_FWD && st_q.seq == st_q.cnt + 6'h02) begin
      tx_char = (st_q.kind == drcu_pkg::K_EP) ? drcu_pkg::CH_PROTO : drcu_pkg::CH_CHKSUM;
    end else begin
      tx_last = 1'b1;
    end

    if (tx_ready_i) begin
      st_d.tx.valid = 1'b0;
    end
    tx_load = st_q.state == drcu_pkg::S_TX && !st_q.fetch && (!st_q.tx.valid || tx_ready_i);
    st_d.fetch = 1'b0;

    unique case (st_q.state)
      drcu_pkg::S_IDLE: begin
        if (rx_take && rx_data_i == drcu_pkg::CH_STX) begin
          st_d.state = drcu_pkg::S_RX;
          st_d.cnt = 6'h00;
          st_d.ovf = 1'b0;
          st_d.sum = 8'h00;
        end
      end
      drcu_pkg::S_RX: begin
        if (rx_take && rx_data_i == drcu_pkg::CH_STX) begin
          // A fresh start abandons the partial frame
          st_d.cnt = 6'h00;
          st_d.ovf = 1'b0;
          st_d.sum = 8'h00;
        end else if (rx_take && rx_data_i == drcu_pkg::CH_ETX) begin
          st_d.state = drcu_pkg::S_EXEC;
          st_d.rx_ready = 1'b0;
        end else if (rx_take) begin
          // Checksum covers all but the last two characters
          if (st_q.cnt >= drcu_pkg::LEN_SUM_START) begin
            st_d.sum = st_q.sum + st_q.c2;
          end
          st_d.c2 = st_q.c1;
          st_d.c1 = rx_data_i;
          unique case (st_q.cnt)
            drcu_pkg::IDX_TYPE: st_d.ftype = rx_data_i;
            drcu_pkg::IDX_ADDRH: st_d.fah = rx_data_i;
            drcu_pkg::IDX_ADDRL: st_d.fal = rx_data_i;
            drcu_pkg::IDX_BODY: st_d.fbody = rx_data_i;
            default: ;
          endcase
          if (st_q.cnt == drcu_pkg::MEM_FULL) begin
            st_d.ovf = 1'b1;
          end else begin
            mem_wr = 1'b1;
            st_d.cnt = st_q.cnt + 6'h01;
          end
        end
      end
      drcu_pkg::S_EXEC: begin
        st_d.state = drcu_pkg::S_TX;
        st_d.seq = 6'h00;
        st_d.fetch = 1'b1;
        if (!addr_match) begin
          st_d.kind = drcu_pkg::K_FWD;
        end else if (!chk_ok) begin
          st_d.kind = drcu_pkg::K_EC;
        end else if (!body_ok) begin
          st_d.kind = drcu_pkg::K_EP;
        end else begin
          st_d.kind = drcu_pkg::K_ACK;
          unique case (st_q.fbody)
            drcu_pkg::CMD_O1_IN2: st_d.route.tgt1 = 1'b1;
            drcu_pkg::CMD_O1_IN1: st_d.route.tgt1 = 1'b0;
            drcu_pkg::CMD_O2_IN2: st_d.route.tgt2 = 1'b1;
            drcu_pkg::CMD_O2_IN1: st_d.route.tgt2 = 1'b0;
            default: st_d.route.fo = 1'b1;
          endcase
        end
      end
      drcu_pkg::S_TX: begin
        if (tx_load) begin
          st_d.tx.valid = 1'b1;
          st_d.tx.valid_data = tx_char;
          st_d.seq = st_q.seq + 6'h01;
          // One wait cycle lets the registered store catch up
          st_d.fetch = 1'b1;
          if (tx_last) begin
            st_d.state = drcu_pkg::S_IDLE;
            st_d.rx_ready = 1'b1;
          end
        end
      end
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q <= '0;
      st_q.route <= drcu_pkg::ROUTE_RST;
      st_q.rx_ready <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign rx_ready_o = st_q.rx_ready;
  assign tx_valid_o = st_q.tx.valid;
  assign tx_data_o = st_q.tx.valid_data;
  assign out1_src_o = st_q.route.act1;
  assign out2_src_o = st_q.route.act2;
  assign routing_and_sync_status_o = st_q.status;
  assign in1_led_o = st_q.leds[5];
  assign in2_led_o = st_q.leds[4];
  assign out1_led_green_o = st_q.leds[3];
  assign out1_led_orange_o = st_q.leds[2];
  assign out2_led_green_o = st_q.leds[1];
  assign out2_led_orange_o = st_q.leds[0];

endmodule
`default_nettype wire

// file: testbench/drcu_checker.sv
/*
  Port assertions for the ring slave command unit.
  Assumes one clock and the asynchronous active low reset of the unit.
*/
`timescale 1ns/1ns
`default_nettype none
module drcu_checker (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_ready_o,
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  input wire logic [7:0] routing_and_sync_status_o,
  input wire logic in1_led_o,
  input wire logic out1_led_green_o,
  input wire logic out1_led_orange_o,
  input wire logic out2_led_orange_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  logic [7:0] st;
  logic etx_in;
  assign st = routing_and_sync_status_o;
  assign etx_in = rx_valid_i && rx_ready_o && (rx_data_i == drcu_pkg::CH_ETX);
  // Sync bit of the target input sits at the index equal to the target bit
  function automatic logic act_ok(input logic [7:0] s, input int t, input int a);
    act_ok = s[a] == (s[s[t]] ? s[t] : (s[drcu_pkg::ST_FO] ? !s[t] : s[t]));
  endfunction
  // ****************************************
  // Properties
  // ****************************************
  // Status lags route by a cycle, so relations are judged once settled
  sequence s_settled;
    $stable(st) ##1 $stable(st);
  endsequence
  property p_rsvd;
    st[drcu_pkg::ST_RSVD] == 1'b0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved status bit set");
  property p_fo;
    $past(arst_n_i) |-> st[drcu_pkg::ST_FO];
  endproperty
  a_fo: assert property (p_fo) else $error("failover not shown enabled");
  property p_hold;
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o);
  endproperty
  a_hold: assert property (p_hold) else $error("tx char dropped before taken");
  property p_busy;
    etx_in |=> !rx_ready_o;
  endproperty
  a_busy: assert property (p_busy) else $error("rx ready after frame end");
  property p_ack;
    etx_in |-> ##4 tx_valid_o && tx_data_o == drcu_pkg::CH_STX;
  endproperty
  a_ack: assert property (p_ack) else $error("reply start late");
  property p_route;
    s_settled |-> act_ok(st, drcu_pkg::ST_TGT1, drcu_pkg::ST_ACT1) && act_ok(st, drcu_pkg::ST_TGT2, drcu_pkg::ST_ACT2);
  endproperty
  a_route: assert property (p_route) else $error("actual route wrong");
  property p_led;
    s_settled |-> in1_led_o == st[drcu_pkg::ST_SYNC1] && out1_led_orange_o == st[drcu_pkg::ST_ACT1]
      && out1_led_green_o == !st[drcu_pkg::ST_ACT1] && out2_led_orange_o == st[drcu_pkg::ST_ACT2];
  endproperty
  a_led: assert property (p_led) else $error("lamp disagrees with status");
  property p_tgt;
    rx_ready_o ##1 rx_ready_o ##1 rx_ready_o |-> $stable(st[drcu_pkg::ST_TGT2:drcu_pkg::ST_TGT1]);
  endproperty
  a_tgt: assert property (p_tgt) else $error("target moved outside a command");
  c_ack: cover property (etx_in);
  c_fail: cover property (st[drcu_pkg::ST_ACT1] != st[drcu_pkg::ST_TGT1]);
  c_err: cover property (tx_valid_o && tx_data_o == drcu_pkg::CH_ERR);
endmodule
bind drcu_ring_slave drcu_checker u_chk (.clk_i(clk_i), .arst_n_i(arst_n_i), .rx_valid_i(rx_valid_i),
  .rx_data_i(rx_data_i), .rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
  .tx_ready_i(tx_ready_i), .routing_and_sync_status_o(routing_and_sync_status_o), .in1_led_o(in1_led_o),
  .out1_led_green_o(out1_led_green_o), .out1_led_orange_o(out1_led_orange_o),
  .out2_led_orange_o(out2_led_orange_o));
`default_nettype wire

// file: testbench/drcu_master.sv
/*
  Ring master model: sends framed characters, collects what comes back.
  Assumes send is called just after a rising edge.
*/
`timescale 1ns/1ns
`default_nettype none
module drcu_master (
  input wire logic clk_i,
  input wire logic slow_i,
  input wire logic rx_ready_i,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_ready_o,
  output logic hang_o
);
  logic [7:0] got[$];
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'hFF;
    tx_ready_o = 1'b1;
    hang_o = 1'b0;
  end
  // Slow mode stalls every other cycle
  always @(posedge clk_i) begin
    if (tx_valid_i && tx_ready_o) got.push_back(tx_data_i);
    tx_ready_o <= slow_i ? !tx_ready_o : 1'b1;
  end
  task automatic put(input logic [7:0] c);
    int n;
    rx_valid_o <= 1'b1;
    rx_data_o <= c;
    n = 0;
    @(posedge clk_i);
    while (!rx_ready_i && n < 300) begin
      n++;
      @(posedge clk_i);
    end
    if (n >= 300) hang_o <= 1'b1;
  endtask
  task automatic send(input logic [7:0] q[$]);
    put(drcu_pkg::CH_STX);
    foreach (q[i]) put(q[i]);
    put(drcu_pkg::CH_ETX);
    rx_valid_o <= 1'b0;
    // Released line shows the inverse, not a stale char
    rx_data_o <= ~drcu_pkg::CH_ETX;
  endtask
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
/*
  Self-checking bench of the ring slave command unit.
  Assumes the master model and the bound checker beside it.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  typedef logic [7:0] drcu_bq_t[$];
  logic clk_i, arst_n_i, sync1, sync2, slow, tgt1, tgt2;
  logic [15:0] own_addr;
  logic rx_valid, rx_ready, tx_valid, tx_ready, hang, src1, src2, l1, l2, g1, o1, g2, o2;
  logic [7:0] rx_data, tx_data, status;
  int n_errors, n_checks;
  always #50 clk_i = ~clk_i;
  drcu_master master (.clk_i(clk_i), .slow_i(slow), .rx_ready_i(rx_ready), .rx_valid_o(rx_valid),
    .rx_data_o(rx_data), .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready), .hang_o(hang));
  drcu_ring_slave dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .own_addr_i(own_addr), .rx_valid_i(rx_valid),
    .rx_data_i(rx_data), .rx_ready_o(rx_ready), .tx_valid_o(tx_valid), .tx_data_o(tx_data),
    .tx_ready_i(tx_ready), .input_one_sync_i(sync1), .input_two_sync_i(sync2), .out1_src_o(src1),
    .out2_src_o(src2), .routing_and_sync_status_o(status), .in1_led_o(l1), .in2_led_o(l2),
    .out1_led_green_o(g1), .out1_led_orange_o(o1), .out2_led_green_o(g2), .out2_led_orange_o(o2));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge hang) begin
    n_errors++;
    results();
  end
  function automatic logic [7:0] hx(input logic [3:0] n);
    hx = (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h57 + {4'h0, n};
  endfunction
  function automatic drcu_bq_t add_ck(input drcu_bq_t q);
    logic [7:0] s;
    s = 8'h00;
    foreach (q[i]) s = s + q[i];
    q.push_back(hx(s[7:4]));
    q.push_back(hx(s[3:0]));
    return q;
  endfunction
  // Failover is never disabled here: no disable command exists
  function automatic logic [7:0] exp_st();
    logic [1:0] s;
    logic a1, a2;
    s = {sync2, sync1};
    a1 = s[tgt1] ? tgt1 : !tgt1;
    a2 = s[tgt2] ? tgt2 : !tgt2;
    return {1'b1, a2, a1, 1'b0, tgt2, tgt1, sync2, sync1};
  endfunction
  task automatic xfer(input drcu_bq_t body, input drcu_bq_t exp);
    int i;
    master.got.delete();
    @(posedge clk_i);
    master.send(body);
    i = 0;
    while (!(master.got.size() > 0 && master.got[$] === drcu_pkg::CH_ETX) && i < 400) begin
      i++;
      @(posedge clk_i);
    end
    if (i >= 400) begin
      n_errors++;
      results();
    end
    check8("reply length", 8'(exp.size()), 8'(master.got.size()));
    foreach (exp[k]) if (k < master.got.size()) check8("reply char", exp[k], master.got[k]);
  endtask
  function automatic drcu_bq_t ack(input logic [7:0] c, input logic [7:0] st);
    drcu_bq_t q;
    q = {drcu_pkg::OWN_CLASS, 8'h30, 8'h32, c, hx(st[7:4]), hx(st[3:0])};
    return {drcu_pkg::CH_STX, add_ck(q), drcu_pkg::CH_ETX};
  endfunction
  task automatic routes(input logic [7:0] st);
    check8("status", st, status);
    check8("out1 source", {7'h00, st[5]}, {7'h00, src1});
    check8("out2 source", {7'h00, st[6]}, {7'h00, src2});
    check8("lamps", {2'h0, sync1, sync2, !st[5], st[5], !st[6], st[6]}, {2'h0, l1, l2, g1, o1, g2, o2});
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    repeat (4) @(posedge clk_i);
    check8("reset outputs", 8'h0A, {3'h0, tx_valid, rx_ready, src1, src2, 1'b0});
    check8("reset status", 8'h00, status);
    repeat (4) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    routes(exp_st());
    $display("test reset done");
  endtask
  task automatic t_cmds;
    logic [7:0] tab[6];
    tab = '{drcu_pkg::CMD_O1_IN2, drcu_pkg::CMD_O2_IN1, drcu_pkg::CMD_FO_EN, drcu_pkg::CMD_O2_IN2,
      drcu_pkg::CMD_O1_IN1, drcu_pkg::CMD_FO_EN};
    for (int i = 0; i < 6; i++) begin
      slow <= i[0];
      if (tab[i] == drcu_pkg::CMD_O1_IN2) tgt1 = 1'b1;
      if (tab[i] == drcu_pkg::CMD_O1_IN1) tgt1 = 1'b0;
      if (tab[i] == drcu_pkg::CMD_O2_IN2) tgt2 = 1'b1;
      if (tab[i] == drcu_pkg::CMD_O2_IN1) tgt2 = 1'b0;
      xfer(add_ck({drcu_pkg::OWN_CLASS, 8'h30, 8'h32, tab[i]}), ack(tab[i], exp_st()));
      routes(exp_st());
    end
    $display("test commands done");
  endtask
  task automatic t_fail;
    sync1 <= 1'b0;
    repeat (8) @(posedge clk_i);
    routes(exp_st());
    xfer(add_ck({drcu_pkg::OWN_CLASS, 8'h30, 8'h32, drcu_pkg::CMD_FO_EN}), ack(drcu_pkg::CMD_FO_EN, exp_st()));
    sync1 <= 1'b1;
    repeat (8) @(posedge clk_i);
    routes(exp_st());
    $display("test failover done");
  endtask
  task automatic t_bad;
    drcu_bq_t q;
    q = add_ck({drcu_pkg::OWN_CLASS, 8'h30, 8'h35, drcu_pkg::CMD_O1_IN2});
    xfer(q, {drcu_pkg::CH_STX, q, drcu_pkg::CH_ETX});
    q = add_ck({8'h64, 8'h30, 8'h32, drcu_pkg::CMD_O1_IN2});
    xfer(q, {drcu_pkg::CH_STX, q, drcu_pkg::CH_ETX});
    q = {drcu_pkg::OWN_CLASS, 8'h30, 8'h32, drcu_pkg::CMD_O1_IN2, 8'h30, 8'h30};
    xfer(q, {drcu_pkg::CH_STX, q, drcu_pkg::CH_ERR, drcu_pkg::CH_CHKSUM, drcu_pkg::CH_ETX});
    q = add_ck({drcu_pkg::OWN_CLASS, 8'h30, 8'h32, 8'h7A});
    xfer(q, {drcu_pkg::CH_STX, q, drcu_pkg::CH_ERR, drcu_pkg::CH_PROTO, drcu_pkg::CH_ETX});
    routes(exp_st());
    $display("test refused frames done");
  endtask
  initial begin
    clk_i = 1'b0;
    arst_n_i = 1'b0;
    sync1 = 1'b1;
    sync2 = 1'b1;
    slow = 1'b0;
    own_addr = 16'h3032;
    tgt1 = 1'b0;
    tgt2 = 1'b1;
    n_errors = 0;
    n_checks = 0;
    t_reset();
    t_cmds();
    t_fail();
    t_bad();
    results();
  end
endmodule
`default_nettype wire
